// *** src/foff_cfg.svh ***
/*
 * constants for the flag offset programming block: bus width codes, offset
 * pointer steps, bit positions and flag validity delays.
 * assumes inclusion by every design file of the block, once per unit.
 */
`ifndef FOFF_CFG_SVH
`define FOFF_CFG_SVH

// widest offset the register holds
`define FOFF_MAX_W 15
// bus width strap codes
`define FOFF_BUS_X36 2'h0
`define FOFF_BUS_X18 2'h1
`define FOFF_BUS_X9 2'h2
// parallel offset pointer positions
`define FOFF_PTR_E_LO 2'h0
`define FOFF_PTR_E_HI 2'h1
`define FOFF_PTR_F_LO 2'h2
`define FOFF_PTR_F_HI 2'h3
// data line skipped when parity is interspersed
`define FOFF_PAR_LINE 8
// bits carried per cycle on the byte bus
`define FOFF_BYTE_W 8
// edges after the completing edge before a flag is valid
`define FOFF_FLAG_DLY 2
// reset values of the thresholds
`define FOFF_RST_EMPTY 15'h007f
`define FOFF_RST_FULL 15'h007f

`endif

// *** src/foff_pkg.sv ***
/*
 * types for the flag offset programming block.
 * assumes foff_cfg.svh for the widths used here.
 */
`include "foff_cfg.svh"

package foff_pkg;

	typedef enum logic [1:0] {
		FOFF_PROG_PARALLEL,
		FOFF_PROG_SERIAL
	} foff_prog_t;

	// control pins as sampled on the clock, all active low
	typedef struct packed {
		logic offset_access_select_b;
		logic shift_enable_b;
		logic write_enable_b;
		logic read_enable_b;
	} foff_ctl_t;

	// whole state of the main module
	typedef struct packed {
		foff_prog_t prog;
		logic [1:0] bus_w;
		logic parity;
		logic [`FOFF_MAX_W-1:0] empty_off;
		logic [`FOFF_MAX_W-1:0] full_off;
		logic [1:0] wr_ptr;
		logic [1:0] rd_ptr;
		logic [4:0] bit_idx;
		logic [35:0] output_bus;
		logic mem_write;
		logic mem_read;
		logic [35:0] mem_data;
	} foff_state_t;

	// validity delay state
	typedef struct packed {
		logic armed;
		logic [1:0] cnt;
		logic valid;
	} foff_valid_t;

endpackage : foff_pkg

// *** src/foff_bus_map.sv ***
/*
 * extracts the offset field from one input bus word.
 * assumes the width and parity straps are stable after master reset.
 */
`timescale 1ns/1ps
`include "foff_cfg.svh"

module foff_bus_map (
	// word and straps
	input wire logic [35:0] word,
	input wire logic [1:0] bus_w,
	input wire logic parity,
	// offset bits, lsb at bit 0
	output logic [15:0] field
);
	import foff_pkg::*;

	// parity line is skipped, bits above it close the gap
	always_comb begin
		if (bus_w == `FOFF_BUS_X9) begin
			field = {8'h00, word[`FOFF_BYTE_W-1:0]}; // R6
		end else if (parity) begin
			field = {word[`FOFF_PAR_LINE+8:`FOFF_PAR_LINE+1], word[`FOFF_PAR_LINE-1:0]}; // R4 R5
		end else begin
			field = word[15:0]; // R4 R5
		end
	end

endmodule : foff_bus_map

// *** src/foff_flag_valid.sv ***
/*
 * holds a flag invalid from programming start until a set number of
 * clock ticks after the completing write.
 * assumes tick marks the rising edges of the flag's own clock.
 */
`timescale 1ns/1ps
`include "foff_cfg.svh"

module foff_flag_valid #(
	parameter int DLY = `FOFF_FLAG_DLY
) (
	// clock and reset
	input wire logic sys_clk,
	input wire logic rst_b,
	// events
	input wire logic invalidate,
	input wire logic done,
	input wire logic tick,
	// result
	output logic valid
);
	import foff_pkg::*;

	foff_valid_t st;
	foff_valid_t next_st;

	// done wins over invalidate so a final bit is never lost
	always_comb begin
		next_st = st;
		if (done) begin
			next_st.armed = 1'b1;
			next_st.cnt = 2'h0;
			next_st.valid = 1'b0;
		end else if (invalidate) begin
			next_st.armed = 1'b0;
			next_st.valid = 1'b0;
		end else if (st.armed && tick) begin
			next_st.cnt = st.cnt + 2'h1;
			if (st.cnt == 2'(DLY - 1)) begin
				next_st.armed = 1'b0;
				next_st.valid = 1'b1;
			end
		end
	end

	// reset values are usable, so flags start valid
	always_ff @(posedge sys_clk) begin
		if (!rst_b) begin
			st <= '{armed: 1'b0, cnt: 2'h0, valid: 1'b1};
		end else begin
			st <= next_st;
		end
	end

	assign valid = st.valid;

endmodule : foff_flag_valid

// *** src/foff_offset_prog.sv ***
/*
 * flag offset programming: parallel and serial loading of the almost-empty
 * and almost-full thresholds, parallel read-back, memory write/read pass
 * strobes and flag validity after a load.
 * assumes one clock standing in for write and read clocks; read_edge marks
 * read clock rising edges; all control inputs synchronous to sys_clk.
 */
// Notes on behaviour
// R1 - both selects low: shift one serial bit
// R2 - serial load is twice the offset width
// R3 - offsets 10 to 15 bits, rest ignored
// R4 - wide bus: empty then full, skip parity
// R5 - half bus: low part from line zero
// R6 - byte bus: four cycles, eight bits each
// R7 - serial mode cannot load one register alone
// R8 - flags invalid until serial load completes
// R9 - serial reload allowed anytime with full set
// R10 - select low, shift high: no shift
// R11 - memory writes allowed around offset loads
// R12 - resumed shifting continues at next bit
// R13 - host pauses by raising one select
// R14 - full flag valid two write edges later
// R15 - empty flag valid two read edges later
// R16 - offsets read back only on output bus
// R17 - programming method fixed at master reset
// R18 - half bus load takes four writes
// R19 - master reset homes both offset pointers
// R20 - serial position wraps after last bit
// R21 - flags undefined during partial programming
`timescale 1ns/1ps
`include "foff_cfg.svh"

module foff_offset_prog #(
	parameter int OFF_W = `FOFF_MAX_W
) (
	// clock and resets
	input wire logic sys_clk,
	input wire logic rst_b,
	input wire logic partial_rst_b,
	// straps, caught during master reset
	input wire logic serial_strap,
	input wire logic [1:0] bus_width_strap,
	input wire logic parity_strap,
	// control pins and read clock marker
	input wire foff_pkg::foff_ctl_t ctl,
	input wire logic read_edge,
	// data
	input wire logic serial_in,
	input wire logic [35:0] input_bus,
	input wire logic [15:0] word_count,
	output logic [35:0] output_bus,
	// memory pass strobes
	output logic mem_write,
	output logic mem_read,
	output logic [35:0] mem_data,
	// thresholds and flags, flags active low
	output logic [`FOFF_MAX_W-1:0] almost_empty_threshold,
	output logic [`FOFF_MAX_W-1:0] almost_full_threshold,
	output logic almost_empty_flag_b,
	output logic almost_full_flag_b,
	output logic empty_flag_valid,
	output logic full_flag_valid
);
	import foff_pkg::*;

	localparam logic [`FOFF_MAX_W-1:0] OFF_MASK = `FOFF_MAX_W'((1 << OFF_W) - 1);
	localparam logic [4:0] LAST_BIT = 5'(2 * OFF_W - 1);
	localparam logic [4:0] OFF_W5 = 5'(OFF_W);

	foff_state_t st;
	foff_state_t next_st;
	logic [15:0] field;
	logic ser_shift;
	logic par_write;
	logic par_read;
	logic done_e;
	logic done_f;
	logic inval_e;
	logic inval_f;

	foff_bus_map u_map (
		.word(input_bus),
		.bus_w(st.bus_w),
		.parity(st.parity),
		.field(field)
	);

	// places offset bits onto the output bus, parity line left clear
	function automatic logic [35:0] pack_word(input logic [15:0] v, input logic [1:0] bw,
		input logic par);
		logic [35:0] w;
		w = 36'h0;
		if (bw == `FOFF_BUS_X9) begin
			w[7:0] = v[7:0];
		end else if (par) begin
			w[7:0] = v[7:0];
			w[16:9] = v[15:8];
		end else begin
			w[15:0] = v;
		end
		return w;
	endfunction : pack_word

	// next pointer step; the wide bus skips the high halves
	function automatic logic [1:0] step_ptr(input logic [1:0] p, input logic [1:0] bw);
		logic [1:0] n;
		n = p + 2'h1;
		if (bw == `FOFF_BUS_X36) begin
			n = p + 2'h2;
		end
		return n;
	endfunction : step_ptr

	// operation decode from the sampled control pins
	always_comb begin
		ser_shift = (st.prog == FOFF_PROG_SERIAL) && !ctl.offset_access_select_b
			&& !ctl.shift_enable_b; // R1 R10 R13
		par_write = (st.prog == FOFF_PROG_PARALLEL) && !ctl.offset_access_select_b
			&& !ctl.write_enable_b;
		par_read = !ctl.offset_access_select_b && !ctl.read_enable_b; // R16
	end

	// completion of each register's load
	always_comb begin
		done_e = 1'b0;
		done_f = 1'b0;
		if (ser_shift) begin
			done_e = (st.bit_idx == LAST_BIT); // R8 R7
			done_f = (st.bit_idx == LAST_BIT);
		end else if (par_write) begin
			if (st.bus_w == `FOFF_BUS_X36) begin
				done_e = (st.wr_ptr == `FOFF_PTR_E_LO);
				done_f = (st.wr_ptr == `FOFF_PTR_F_LO);
			end else begin
				done_e = (st.wr_ptr == `FOFF_PTR_E_HI); // R18
				done_f = (st.wr_ptr == `FOFF_PTR_F_HI);
			end
		end
		// any other offset write leaves the flag mid-update
		inval_e = (ser_shift || (par_write && !st.wr_ptr[1])) && !done_e; // R21 R8
		inval_f = (ser_shift || (par_write && st.wr_ptr[1])) && !done_f; // R21 R8
	end

	// next state
	always_comb begin
		next_st = st;
		next_st.mem_write = ctl.offset_access_select_b && !ctl.write_enable_b; // R11
		next_st.mem_read = ctl.offset_access_select_b && !ctl.read_enable_b;
		if (next_st.mem_write) begin
			next_st.mem_data = input_bus;
		end
		// serial path: fixed empty-then-full order, one bit per edge
		if (ser_shift) begin
			if (st.bit_idx < OFF_W5) begin
				next_st.empty_off[st.bit_idx[3:0]] = serial_in; // R1 R7
			end else begin
				next_st.full_off[4'(st.bit_idx - OFF_W5)] = serial_in; // R1 R7
			end
			// position survives pauses, so a resume picks up the next bit
			if (st.bit_idx == LAST_BIT) begin
				next_st.bit_idx = 5'h00; // R20 R2 R9
			end else begin
				next_st.bit_idx = st.bit_idx + 5'h01; // R12
			end
		end
		// parallel path: low and high parts per pointer
		if (par_write) begin
			case (st.wr_ptr)
				`FOFF_PTR_E_LO: begin
					if (st.bus_w == `FOFF_BUS_X9) begin
						next_st.empty_off[7:0] = field[7:0]; // R6
					end else begin
						next_st.empty_off = field[`FOFF_MAX_W-1:0] & OFF_MASK; // R4 R5 R3
					end
				end
				`FOFF_PTR_E_HI: begin
					if (st.bus_w == `FOFF_BUS_X9) begin
						next_st.empty_off[14:8] = field[6:0] & OFF_MASK[14:8]; // R6 R3
					end
				end
				`FOFF_PTR_F_LO: begin
					if (st.bus_w == `FOFF_BUS_X9) begin
						next_st.full_off[7:0] = field[7:0]; // R6
					end else begin
						next_st.full_off = field[`FOFF_MAX_W-1:0] & OFF_MASK; // R4 R5 R3
					end
				end
				`FOFF_PTR_F_HI: begin
					if (st.bus_w == `FOFF_BUS_X9) begin
						next_st.full_off[14:8] = field[6:0] & OFF_MASK[14:8]; // R6 R3
					end
				end
				default: begin
					next_st.full_off = st.full_off;
				end
			endcase
			next_st.wr_ptr = step_ptr(st.wr_ptr, st.bus_w); // R18 R6
		end
		// read-back overwrites the output word, independent pointer
		if (par_read) begin
			case (st.rd_ptr)
				`FOFF_PTR_E_LO: next_st.output_bus = pack_word((st.bus_w == `FOFF_BUS_X9) ?
					{8'h00, st.empty_off[7:0]} : {1'b0, st.empty_off}, st.bus_w, st.parity);
				`FOFF_PTR_E_HI: next_st.output_bus = pack_word((st.bus_w == `FOFF_BUS_X9) ?
					{9'h000, st.empty_off[14:8]} : 16'h0000, st.bus_w, st.parity);
				`FOFF_PTR_F_LO: next_st.output_bus = pack_word((st.bus_w == `FOFF_BUS_X9) ?
					{8'h00, st.full_off[7:0]} : {1'b0, st.full_off}, st.bus_w, st.parity);
				`FOFF_PTR_F_HI: next_st.output_bus = pack_word((st.bus_w == `FOFF_BUS_X9) ?
					{9'h000, st.full_off[14:8]} : 16'h0000, st.bus_w, st.parity);
				default: next_st.output_bus = 36'h0;
			endcase
			next_st.rd_ptr = step_ptr(st.rd_ptr, st.bus_w); // R16
		end
	end

	// straps caught only in master reset; partial reset keeps all settings
	always_ff @(posedge sys_clk) begin
		if (!rst_b) begin
			st.prog <= serial_strap ? FOFF_PROG_SERIAL : FOFF_PROG_PARALLEL; // R17
			st.bus_w <= bus_width_strap;
			st.parity <= parity_strap;
			st.empty_off <= `FOFF_RST_EMPTY & OFF_MASK;
			st.full_off <= `FOFF_RST_FULL & OFF_MASK;
			st.wr_ptr <= `FOFF_PTR_E_LO; // R19
			st.rd_ptr <= `FOFF_PTR_E_LO; // R19
			st.bit_idx <= 5'h00;
			st.output_bus <= 36'h0;
			st.mem_write <= 1'b0;
			st.mem_read <= 1'b0;
			st.mem_data <= 36'h0;
		end else if (!partial_rst_b) begin
			st <= st;
			st.mem_write <= 1'b0;
			st.mem_read <= 1'b0;
		end else begin
			st <= next_st;
		end
	end

	// full flag counts write edges, empty flag counts read edges
	foff_flag_valid #(.DLY(`FOFF_FLAG_DLY)) u_full_valid (
		.sys_clk(sys_clk),
		.rst_b(rst_b),
		.invalidate(inval_f),
		.done(done_f),
		.tick(1'b1),
		.valid(full_flag_valid) // R14
	);

	foff_flag_valid #(.DLY(`FOFF_FLAG_DLY)) u_empty_valid (
		.sys_clk(sys_clk),
		.rst_b(rst_b),
		.invalidate(inval_e),
		.done(done_e),
		.tick(read_edge),
		.valid(empty_flag_valid) // R15
	);

	// flags compare fill level; held inactive while their offset is stale
	always_comb begin
		almost_empty_flag_b = !(empty_flag_valid && (word_count <= {1'b0, st.empty_off})); // R21
		almost_full_flag_b = !(full_flag_valid &&
			(word_count >= (16'hffff - {1'b0, st.full_off}))); // R21
	end

	assign output_bus = st.output_bus;
	assign mem_write = st.mem_write;
	assign mem_read = st.mem_read;
	assign mem_data = st.mem_data;
	assign almost_empty_threshold = st.empty_off;
	assign almost_full_threshold = st.full_off;

	// serial shift moves the bit position by one
	property p_ser_step;
		@(posedge sys_clk) disable iff (!rst_b || !partial_rst_b)
		ser_shift && st.bit_idx != LAST_BIT |=> st.bit_idx == $past(st.bit_idx) + 5'h01;
	endproperty
	a_ser_step: assert property (p_ser_step) else $error("serial position did not step"); // R1

	// wrap after the last bit
	property p_ser_wrap;
		@(posedge sys_clk) disable iff (!rst_b || !partial_rst_b)
		ser_shift && st.bit_idx == LAST_BIT |=> st.bit_idx == 5'h00;
	endproperty
	a_ser_wrap: assert property (p_ser_wrap) else $error("serial position did not wrap"); // R20

	// shift blocked keeps the position
	property p_no_shift;
		@(posedge sys_clk) disable iff (!rst_b || !partial_rst_b)
		!ctl.offset_access_select_b && ctl.shift_enable_b && ctl.write_enable_b
			|=> $stable(st.bit_idx);
	endproperty
	a_no_shift: assert property (p_no_shift) else $error("bit shifted while disabled"); // R10

	// the shifted bit lands in the empty register
	property p_ser_bit;
		@(posedge sys_clk) disable iff (!rst_b || !partial_rst_b)
		ser_shift && st.bit_idx < OFF_W5 |=> st.empty_off[$past(st.bit_idx[3:0])] == $past(serial_in);
	endproperty
	a_ser_bit: assert property (p_ser_bit) else $error("serial bit not stored"); // R7

	// completing edge followed by two quiet edges
	sequence s_full_done;
		done_f ##1 (!done_f && !inval_f) [*2];
	endsequence

	// valid is registered, so it shows one edge after the second quiet edge
	property p_full_valid;
		@(posedge sys_clk) disable iff (!rst_b)
		s_full_done |=> full_flag_valid;
	endproperty
	a_full_valid: assert property (p_full_valid) else $error("full flag not valid in time"); // R14

	// not early either
	property p_full_not_early;
		@(posedge sys_clk) disable iff (!rst_b)
		done_f |=> !full_flag_valid ##1 !full_flag_valid;
	endproperty
	a_full_not_early: assert property (p_full_not_early) else $error("full flag valid early"); // R14

	// empty flag still invalid one edge after completion, no read edge
	property p_empty_wait;
		@(posedge sys_clk) disable iff (!rst_b)
		done_e ##1 (!read_edge && !done_e && !inval_e) |-> !empty_flag_valid;
	endproperty
	a_empty_wait: assert property (p_empty_wait) else $error("empty flag valid early"); // R15

	// flag invalid during serial programming
	property p_ser_invalid;
		@(posedge sys_clk) disable iff (!rst_b)
		ser_shift && !done_f |=> !full_flag_valid && !empty_flag_valid;
	endproperty
	a_ser_invalid: assert property (p_ser_invalid) else $error("flag valid mid load"); // R8

	// memory write strobe follows a write with the offset select high
	property p_mem_write;
		@(posedge sys_clk) disable iff (!rst_b || !partial_rst_b)
		ctl.offset_access_select_b && !ctl.write_enable_b |=> mem_write && mem_data == $past(input_bus);
	endproperty
	a_mem_write: assert property (p_mem_write) else $error("memory write lost"); // R11

endmodule : foff_offset_prog

// *** test/foff_host_model.sv ***
/*
 * host model: drives the control pins, the serial bit and the input bus of the block.
 * assumes the bench calls one task at a time; each request lasts exactly one clock.
 */
`timescale 1ns/1ps

module foff_host_model (
	// clock
	input wire logic sys_clk,
	// pins toward the block
	output foff_pkg::foff_ctl_t ctl,
	output logic serial_in,
	output logic [35:0] input_bus
);
	import foff_pkg::*;

	// idle at start, all selects high
	initial begin
		ctl = 4'hf;
		serial_in = 1'b0;
		input_bus = 36'h0;
	end

	// one request, changed just after an edge and held for the whole cycle
	task automatic op(input logic [3:0] c, input logic [35:0] w, input logic si);
		@(posedge sys_clk);
		ctl <= c;
		input_bus <= w;
		serial_in <= si;
	endtask : op

	// released lines flip, so a stale value never passes for a live one
	task automatic idle();
		@(posedge sys_clk);
		ctl <= 4'hf;
		input_bus <= ~input_bus;
		serial_in <= ~serial_in;
	endtask : idle

	// serial shift, empty offset lsb first, full offset msb last
	task automatic shift(input logic [29:0] bits, input int lo, input int hi);
		for (int i = lo; i <= hi; i++) begin
			op(4'h3, ~input_bus, bits[i]);
		end
	endtask : shift
endmodule : foff_host_model

// *** test/tb_top.sv ***
/*
 * bench for the flag offset block: parallel loads in every bus width, read-back,
 * serial load with pause, memory pass, flag validity and reload.
 * assumes foff_host_model drives the control pins and the data input.
 */
`timescale 1ns/1ps
`include "foff_cfg.svh"
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin num_errors++; $display("unexpected at %0t: got %0h exp %0h", $time, (g), (e)); end end

module tb_top;
	import foff_pkg::*;

	typedef struct packed {
		logic [1:0] bus_w;
		logic parity;
		logic [3:0][35:0] words;
		logic [14:0] exp_empty;
		logic [14:0] exp_full;
	} foff_tb_row_t;

	// one row per bus width, x36 twice with parity off and on; unused lines carry ones that must be ignored
	localparam foff_tb_row_t ROWS [4] = '{
		'{`FOFF_BUS_X36, 1'b0, {36'h0, 36'h0, 36'h2bcd, 36'hf_ffff_5a5a}, 15'h5a5a, 15'h2bcd},
		'{`FOFF_BUS_X36, 1'b1, {36'h0, 36'h0, 36'he101, 36'h2534}, 15'h1234, 15'h7001},
		'{`FOFF_BUS_X18, 1'b0, {36'hffff, 36'h0155, 36'hffff, 36'hbc3c}, 15'h3c3c, 15'h0155},
		'{`FOFF_BUS_X9, 1'b0, {36'h07f, 36'h0e0, 36'h0aa, 36'h181}, 15'h2a81, 15'h7fe0}
	};

	logic sys_clk;
	logic rst_b = 1'b0;
	logic partial_rst_b = 1'b1;
	logic serial_strap = 1'b0;
	logic [1:0] bus_width_strap = 2'h0;
	logic parity_strap = 1'b0;
	logic read_edge = 1'b0;
	logic [15:0] word_count = 16'h0;
	foff_ctl_t ctl;
	logic serial_in;
	logic [35:0] input_bus;
	logic [35:0] output_bus;
	logic mem_write;
	logic mem_read;
	logic [35:0] mem_data;
	logic [14:0] almost_empty_threshold;
	logic [14:0] almost_full_threshold;
	logic almost_empty_flag_b;
	logic almost_full_flag_b;
	logic empty_flag_valid;
	logic full_flag_valid;
	int num_errors = 0;
	int cmp_count = 0;
	logic [29:0] sbits = {15'h64c3, 15'h1b3c};

	foff_offset_prog i_dut (
		.sys_clk(sys_clk), .rst_b(rst_b), .partial_rst_b(partial_rst_b),
		.serial_strap(serial_strap), .bus_width_strap(bus_width_strap),
		.parity_strap(parity_strap), .ctl(ctl), .read_edge(read_edge),
		.serial_in(serial_in), .input_bus(input_bus), .word_count(word_count),
		.output_bus(output_bus), .mem_write(mem_write), .mem_read(mem_read),
		.mem_data(mem_data), .almost_empty_threshold(almost_empty_threshold),
		.almost_full_threshold(almost_full_threshold),
		.almost_empty_flag_b(almost_empty_flag_b), .almost_full_flag_b(almost_full_flag_b),
		.empty_flag_valid(empty_flag_valid), .full_flag_valid(full_flag_valid)
	);

	foff_host_model i_host (
		.sys_clk(sys_clk), .ctl(ctl), .serial_in(serial_in), .input_bus(input_bus)
	);

	// 200 MHz clock
	initial begin
		sys_clk = 1'b0;
		forever #2.5 sys_clk = ~sys_clk;
	end

	// verdict and end of run, shared with the watchdog
	task automatic tally_and_finish();
		$display("comparisons %0d mismatches %0d", cmp_count, num_errors);
		if (num_errors == 0 && cmp_count > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask : tally_and_finish

	// master reset for 20 cycles with the straps held throughout
	task automatic do_reset(input logic ser, input logic [1:0] bw, input logic par);
		@(posedge sys_clk);
		rst_b <= 1'b0;
		serial_strap <= ser;
		bus_width_strap <= bw;
		parity_strap <= par;
		repeat (20) @(posedge sys_clk);
		rst_b <= 1'b1;
	endtask : do_reset

	// hang guard, far above the few hundred cycles the tests need
	initial begin
		repeat (5000) @(posedge sys_clk);
		num_errors++;
		tally_and_finish();
	end

	initial begin
		do_reset(1'b0, `FOFF_BUS_X36, 1'b0);
		#1;
		`CHK(almost_empty_threshold, 15'h007f)
		`CHK(full_flag_valid, 1'b1)
		`CHK(output_bus, 36'h0)
		$display("done: reset values");
		// parallel loads, one reset per table row
		foreach (ROWS[r]) begin
			do_reset(1'b0, ROWS[r].bus_w, ROWS[r].parity);
			for (int k = 0; k < ((ROWS[r].bus_w == `FOFF_BUS_X36) ? 2 : 4); k++) begin
				i_host.op(4'h5, ROWS[r].words[k], 1'b0);
			end
			i_host.idle();
			#1;
			`CHK(almost_empty_threshold, ROWS[r].exp_empty)
			`CHK(almost_full_threshold, ROWS[r].exp_full)
			if (r == 0) begin
				i_host.op(4'h6, 36'h0, 1'b0);
				i_host.op(4'h6, 36'h0, 1'b0);
				#1;
				`CHK(output_bus, 36'(ROWS[r].exp_empty))
				i_host.idle();
				#1;
				`CHK(output_bus, 36'(ROWS[r].exp_full))
			end
			$display("done: parallel row %0d", r);
		end
		// serial load interrupted by a blocked shift and memory traffic
		do_reset(1'b1, `FOFF_BUS_X36, 1'b0);
		i_host.op(4'h5, 36'h7fff, 1'b0);
		i_host.shift(sbits, 0, 9);
		repeat (3) i_host.op(4'h7, 36'h0, ~sbits[10]);
		i_host.op(4'hd, 36'h9_8765_4321, 1'b0);
		i_host.op(4'he, 36'h0, 1'b0);
		#1;
		`CHK(mem_write, 1'b1)
		`CHK(mem_data, 36'h9_8765_4321)
		`CHK(full_flag_valid, 1'b0)
		`CHK(almost_full_flag_b, 1'b1)
		i_host.idle();
		#1;
		`CHK(mem_read, 1'b1)
		`CHK(mem_write, 1'b0)
		i_host.shift(sbits, 10, 29);
		i_host.idle();
		#1;
		`CHK(almost_empty_threshold, 15'h1b3c)
		`CHK(almost_full_threshold, 15'h64c3)
		`CHK(full_flag_valid, 1'b0)
		@(posedge sys_clk);
		#1;
		`CHK(full_flag_valid, 1'b0)
		@(posedge sys_clk);
		#1;
		`CHK(full_flag_valid, 1'b1)
		`CHK(empty_flag_valid, 1'b0)
		@(posedge sys_clk) read_edge <= 1'b1;
		@(posedge sys_clk);
		@(posedge sys_clk) read_edge <= 1'b0;
		#1;
		`CHK(empty_flag_valid, 1'b1)
		`CHK(almost_empty_flag_b, 1'b0)
		$display("done: serial load");
		// partial reset keeps the offsets
		@(posedge sys_clk) partial_rst_b <= 1'b0;
		@(posedge sys_clk) partial_rst_b <= 1'b1;
		#1;
		`CHK(almost_full_threshold, 15'h64c3)
		// a second full set wraps and replaces both offsets
		i_host.shift(~sbits, 0, 29);
		i_host.idle();
		#1;
		`CHK(almost_empty_threshold, 15'h64c3)
		`CHK(almost_full_threshold, 15'h1b3c)
		$display("done: serial reload");
		tally_and_finish();
	end
endmodule : tb_top
